/* bmd_regs.sv */
// buffer manager drop counters, init status and random discard table
// assumes: classic wishbone master on clk_i, drop events and usage on clk_i
//
// Contract
// - count port 1 discarded packets, 32 bits
// - count port 2 discarded packets, 32 bits
// - count space, red and yellow discards
// - counter read returns value then clears
// - counter saturates at all ones
// - ready flag is status bit 0
// - ready zero after reset, self-sets later
// - init sequence runs on every reset
// - command write stores value, launches access
// - command bit 4: one reads, zero writes
// - command bits 3:0 pick table entry
// - entries map usage in 8/16/32 steps
// - usage range selects applied discard probability
// - read command loads read data register
// - entries are 10-bit probability in 1/1024
// - table not initialized by reset
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module bmd_regs
  import bmd_pkg::*;
#(
  parameter int INIT_CYCLES = BMD_INIT_CYCLES
) (
  input wire logic clk_i, // core clock, 50 MHz
  input wire logic reset_n_i, // switch fabric reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [BMD_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire bmd_drop_t port1_drop_i, // port 1 drop causes, per packet
  input wire bmd_drop_t port2_drop_i, // port 2 drop causes, per packet
  input wire logic lookup_done_i, // address lookup table init done
  input wire logic [BMD_USAGE_W-1:0] usage_i, // ingress port buffer usage
  output logic [BMD_PROB_W-1:0] prob_o, // yellow discard probability
  output logic tables_ready_o // buffer manager tables ready
);

  localparam logic [8:0] SWEEP_LAST = 9'(INIT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic req, wr, rd;
  logic hit_cnt1, hit_cnt2, hit_sts, hit_cmd, hit_wdat, hit_rdat;

  // a request is taken once, in the cycle before ack rises
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign hit_cnt1 = (wb_adr_i[BMD_ADR_W-1:2] == BMD_IDX_PORT1_CNT);
  assign hit_cnt2 = (wb_adr_i[BMD_ADR_W-1:2] == BMD_IDX_PORT2_CNT);
  assign hit_sts = (wb_adr_i[BMD_ADR_W-1:2] == BMD_IDX_INIT_STS);
  assign hit_cmd = (wb_adr_i[BMD_ADR_W-1:2] == BMD_IDX_TBL_CMD);
  assign hit_wdat = (wb_adr_i[BMD_ADR_W-1:2] == BMD_IDX_TBL_WDATA);
  assign hit_rdat = (wb_adr_i[BMD_ADR_W-1:2] == BMD_IDX_TBL_RDATA);

  ////////////////////////////////////////////////////////////////////////
  // drop counters

  logic [31:0] cnt1_ff, nxt_cnt1, cnt2_ff, nxt_cnt2;
  logic ev1, ev2, rd_cnt1, rd_cnt2;

  // any cause drops the packet once
  assign ev1 = port1_drop_i.space | port1_drop_i.red | port1_drop_i.yellow;
  assign ev2 = port2_drop_i.space | port2_drop_i.red | port2_drop_i.yellow;
  assign rd_cnt1 = rd & hit_cnt1;
  assign rd_cnt2 = rd & hit_cnt2;

  // clear on read, event in the read cycle survives as one
  always_comb begin
    nxt_cnt1 = cnt1_ff;
    nxt_cnt2 = cnt2_ff;
    if (rd_cnt1) begin
      nxt_cnt1 = ev1 ? 32'h0000_0001 : BMD_CNT_RST;
    end else if (ev1 && cnt1_ff != BMD_CNT_MAX) begin
      nxt_cnt1 = cnt1_ff + 32'h0000_0001;
    end
    if (rd_cnt2) begin
      nxt_cnt2 = ev2 ? 32'h0000_0001 : BMD_CNT_RST;
    end else if (ev2 && cnt2_ff != BMD_CNT_MAX) begin
      nxt_cnt2 = cnt2_ff + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // table initialization sequence

  bmd_init_st_t st_ff, nxt_st;
  logic [8:0] sweep_ff, nxt_sweep;
  logic ready_ff, nxt_ready;

  // restarts from the sweep on every fabric reset
  always_comb begin
    nxt_st = st_ff;
    nxt_sweep = sweep_ff;
    nxt_ready = 1'b0;
    case (st_ff)
      BMD_ST_SWEEP: begin
        nxt_sweep = sweep_ff + 9'h001;
        if (sweep_ff == SWEEP_LAST) begin
          nxt_st = BMD_ST_WAIT_LOOKUP;
        end
      end
      BMD_ST_WAIT_LOOKUP: begin
        if (lookup_done_i) begin
          nxt_st = BMD_ST_READY;
          nxt_ready = 1'b1;
        end
      end
      BMD_ST_READY: begin
        nxt_ready = 1'b1;
      end
      default: begin
        nxt_st = BMD_ST_SWEEP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // discard table command, data and lookup

  logic [BMD_CMD_W-1:0] cmd_ff, nxt_cmd;
  logic [BMD_PROB_W-1:0] wdat_ff, nxt_wdat, rdat_ff, nxt_rdat, prob_ff, nxt_prob;
  logic [BMD_PROB_W-1:0] tbl_mem [BMD_TBL_DEPTH];
  logic cmd_wr, tbl_we;
  logic [BMD_TBL_IDX_W-1:0] use_idx;
  logic [BMD_PROB_W-1:0] cmd_entry;

  assign cmd_wr = wr & hit_cmd & wb_sel_i[0];
  assign tbl_we = cmd_wr & ~wb_dat_i[BMD_CMD_DIR_BIT];
  assign cmd_entry = tbl_mem[wb_dat_i[BMD_TBL_IDX_W-1:0]];

  // usage to entry: 8-buffer, then 16, then 32-buffer steps
  always_comb begin
    if (usage_i < BMD_USE_FINE_END) begin
      use_idx = {1'b0, usage_i[5:3]};
    end else if (usage_i < BMD_USE_MID_END) begin
      use_idx = {2'b10, usage_i[5:4]};
    end else begin
      use_idx = {2'b11, usage_i[6:5]};
    end
  end

  // command store and launch, write data, read data, lookup
  always_comb begin
    nxt_cmd = cmd_ff;
    nxt_wdat = wdat_ff;
    nxt_rdat = rdat_ff;
    nxt_prob = tbl_mem[use_idx];
    if (cmd_wr) begin
      nxt_cmd = wb_dat_i[BMD_CMD_W-1:0];
      if (wb_dat_i[BMD_CMD_DIR_BIT]) begin
        nxt_rdat = cmd_entry;
      end
    end
    if (wr && hit_wdat) begin
      if (wb_sel_i[0]) begin
        nxt_wdat[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        nxt_wdat[9:8] = wb_dat_i[9:8];
      end
    end
  end

  // table has no reset, host must fill it
  always_ff @(posedge clk_i) begin
    if (tbl_we) begin
      tbl_mem[wb_dat_i[BMD_TBL_IDX_W-1:0]] <= wdat_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge

  always_comb begin
    nxt_ack = req;
    nxt_dat = 32'h0000_0000;
    if (rd) begin
      if (hit_cnt1) begin
        nxt_dat = cnt1_ff;
      end else if (hit_cnt2) begin
        nxt_dat = cnt2_ff;
      end else if (hit_sts) begin
        nxt_dat[BMD_READY_BIT] = ready_ff;
      end else if (hit_cmd) begin
        nxt_dat[BMD_CMD_W-1:0] = cmd_ff;
      end else if (hit_wdat) begin
        nxt_dat[BMD_PROB_W-1:0] = wdat_ff;
      end else if (hit_rdat) begin
        nxt_dat[BMD_PROB_W-1:0] = rdat_ff;
      end
    end
  end

  // all state registers except the discard table memory
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      cnt1_ff <= BMD_CNT_RST;
      cnt2_ff <= BMD_CNT_RST;
      st_ff <= BMD_ST_SWEEP;
      sweep_ff <= 9'h000;
      ready_ff <= 1'b0;
      cmd_ff <= BMD_CMD_RST;
      wdat_ff <= BMD_PROB_RST;
      rdat_ff <= BMD_PROB_RST;
      prob_ff <= BMD_PROB_RST;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      cnt1_ff <= nxt_cnt1;
      cnt2_ff <= nxt_cnt2;
      st_ff <= nxt_st;
      sweep_ff <= nxt_sweep;
      ready_ff <= nxt_ready;
      cmd_ff <= nxt_cmd;
      wdat_ff <= nxt_wdat;
      rdat_ff <= nxt_rdat;
      prob_ff <= nxt_prob;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign prob_o = prob_ff;
  assign tables_ready_o = ready_ff;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_req_taken;
    wb_cyc_i && wb_stb_i && !ack_ff;
  endsequence

  sequence s_ack_pulse;
    ack_ff ##1 !ack_ff;
  endsequence

  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_req_taken |=> s_ack_pulse)
    else $error("ack not a single cycle pulse after request");

  cnt1_inc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ev1 && !rd_cnt1 && cnt1_ff != BMD_CNT_MAX) |=> cnt1_ff == $past(cnt1_ff) + 32'h1)
    else $error("port 1 count did not step by one");

  cnt2_inc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ev2 && !rd_cnt2 && cnt2_ff != BMD_CNT_MAX) |=> cnt2_ff == $past(cnt2_ff) + 32'h1)
    else $error("port 2 count did not step by one");

  cnt_saturate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cnt1_ff == BMD_CNT_MAX && !rd_cnt1) |=> cnt1_ff == BMD_CNT_MAX)
    else $error("port 1 count wrapped past maximum");

  read_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_cnt1 && !ev1) |=> (cnt1_ff == 32'h0 && wb_dat_o == $past(cnt1_ff) && wb_ack_o))
    else $error("port 1 read did not return value and clear");

  ready_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_ff != BMD_ST_READY) |-> !tables_ready_o)
    else $error("ready flag set before init done");

  ready_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_ff == BMD_ST_WAIT_LOOKUP && lookup_done_i) |=> tables_ready_o [*2])
    else $error("ready flag did not self-set");

  sweep_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(st_ff == BMD_ST_WAIT_LOOKUP) |-> $past(sweep_ff) == SWEEP_LAST)
    else $error("init sweep length wrong");

  cmd_store_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_wr |=> cmd_ff == $past(wb_dat_i[BMD_CMD_W-1:0]))
    else $error("command value not stored");

  tbl_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmd_wr && wb_dat_i[BMD_CMD_DIR_BIT]) |=> rdat_ff == $past(cmd_entry))
    else $error("read command did not load read data");

  sts_reserved_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd && hit_sts) |=> wb_dat_o[31:1] == 31'h0 && wb_dat_o[0] == $past(ready_ff))
    else $error("status reserved bits not zero");

endmodule

`default_nettype wire

/* bmd_pkg.sv */
// constants, types and register map of the buffer manager discard slice
// assumes: wishbone byte addressing, register index times four is the address
package bmd_pkg;

  // register indices; byte address is four times the index
  localparam int BMD_ADR_W = 16;
  localparam logic [13:0] BMD_IDX_PORT1_CNT = 14'h1C06;
  localparam logic [13:0] BMD_IDX_PORT2_CNT = 14'h1C07;
  localparam logic [13:0] BMD_IDX_INIT_STS = 14'h1C08;
  localparam logic [13:0] BMD_IDX_TBL_CMD = 14'h1C09;
  localparam logic [13:0] BMD_IDX_TBL_WDATA = 14'h1C0A;
  localparam logic [13:0] BMD_IDX_TBL_RDATA = 14'h1C0B;

  // field positions and widths
  localparam int BMD_CMD_DIR_BIT = 4;
  localparam int BMD_CMD_IDX_LSB = 0;
  localparam int BMD_CMD_W = 5;
  localparam int BMD_TBL_IDX_W = 4;
  localparam int BMD_TBL_DEPTH = 16;
  localparam int BMD_PROB_W = 10;
  localparam int BMD_READY_BIT = 0;
  localparam int BMD_USAGE_W = 8;

  // reset values and counter saturation value
  localparam logic [31:0] BMD_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] BMD_CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [4:0] BMD_CMD_RST = 5'h00;
  localparam logic [9:0] BMD_PROB_RST = 10'h000;

  // usage range boundaries of the discard table
  localparam logic [7:0] BMD_USE_FINE_END = 8'h40;
  localparam logic [7:0] BMD_USE_MID_END = 8'h80;

  // table initialization sweep length in core clocks
  localparam int BMD_INIT_CYCLES = 256;

  // causes for which an ingress packet is dropped
  typedef struct packed {
    logic space;
    logic red;
    logic yellow;
  } bmd_drop_t;

  // initialization sequence after switch fabric reset
  typedef enum logic [1:0] {
    BMD_ST_SWEEP,
    BMD_ST_WAIT_LOOKUP,
    BMD_ST_READY
  } bmd_init_st_t;

endpackage

/* bmd_testbench.sv */
// self-checking bench for the discard counters, ready flag and discard table
// assumes: bmd_regs with INIT_CYCLES of 4, classic wishbone ack one cycle after take
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench
  import bmd_pkg::*;
;

  logic clk_i, reset_n_i, wb_cyc, wb_stb, wb_we, wb_ack, lookup_done, ready;
  logic [15:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q, seed, c1, c2, r;
  bmd_drop_t drop1, drop2;
  logic [7:0] usage, u_prev;
  logic [9:0] prob, tbl [16];
  int n_mismatch, samples_checked, cycles;

  bmd_regs #(.INIT_CYCLES(4)) u_bmd_regs (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .port1_drop_i(drop1), .port2_drop_i(drop2),
    .lookup_done_i(lookup_done), .usage_i(usage), .prob_o(prob), .tables_ready_o(ready)
  );

  // 50 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic test_done();
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // one classic wishbone cycle, held until ack is sampled high at a rising edge
  task automatic bus(input logic we, input logic [13:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= d;
    wb_sel <= 4'hF;
    // ack and read data are read before this edge's updates land
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) n_mismatch++;
    q = wb_rdat;
    // release at the edge that saw ack, cyc stays low one cycle
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  // expected table index for a buffer usage level
  function automatic int use_idx(input int u);
    if (u < 64) return u / 8;
    if (u < 128) return 8 + (u - 64) / 16;
    return 12 + (u - 128) / 32;
  endfunction

  // reset pulse, then ready follows sweep and lookup completion
  task automatic boot();
    int n;
    @(posedge clk_i);
    lookup_done <= 1'b0;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1 `CHK(ready, 1'b0)
    repeat (10) @(posedge clk_i);
    #1 `CHK(ready, 1'b0)
    @(posedge clk_i);
    lookup_done <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (ready !== 1'b1 && n < 20);
    `CHK(ready, 1'b1)
    bus(1'b0, BMD_IDX_INIT_STS, 32'h0);
    `CHK(q, 32'h0000_0001)
  endtask

  // random drop traffic on both ports, modelled in c1 and c2
  task automatic drops(input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge clk_i);
      r = $random(seed);
      drop1 <= bmd_drop_t'(r[2:0]);
      drop2 <= bmd_drop_t'(r[5:3]);
      if (r[2:0] != 3'h0 && c1 != 32'hFFFF_FFFF) c1++;
      if (r[5:3] != 3'h0 && c2 != 32'hFFFF_FFFF) c2++;
    end
    @(posedge clk_i);
    drop1 <= '0;
    drop2 <= '0;
  endtask

  initial begin
    seed = 32'h4173FB25;
    {wb_cyc, wb_stb, wb_we, lookup_done, reset_n_i} = '0;
    {wb_adr, wb_sel, wb_wdat, usage, u_prev, c1, c2} = '0;
    drop1 = '0;
    drop2 = '0;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    boot();
    bus(1'b0, BMD_IDX_TBL_CMD, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, 14'h1C0F, 32'h0);
    `CHK(q, 32'h0)
    // counters: count, return on read, clear after read
    for (int k = 0; k < 3; k++) begin
      drops(k * 17);
      bus(1'b0, BMD_IDX_PORT1_CNT, 32'h0);
      `CHK(q, c1)
      bus(1'b0, BMD_IDX_PORT2_CNT, 32'h0);
      `CHK(q, c2)
      bus(1'b0, BMD_IDX_PORT1_CNT, 32'h0);
      `CHK(q, 32'h0)
      c1 = 0;
      bus(1'b0, BMD_IDX_PORT2_CNT, 32'h0);
      `CHK(q, 32'h0)
      c2 = 0;
    end
    // drop held across a read: old value returned, the drop in that cycle kept
    @(posedge clk_i);
    drop1 <= 3'h4;
    bus(1'b0, BMD_IDX_PORT1_CNT, 32'h0);
    drop1 <= '0;
    `CHK(q, 32'h1)
    bus(1'b0, BMD_IDX_PORT1_CNT, 32'h0);
    `CHK(q, 32'h2)
    // fill the table with random reserved bits in every write
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      tbl[i] = r[9:0];
      bus(1'b1, BMD_IDX_TBL_WDATA, r);
      bus(1'b0, BMD_IDX_TBL_WDATA, 32'h0);
      `CHK(q, {22'h0, tbl[i]})
      r = $random(seed);
      bus(1'b1, BMD_IDX_TBL_CMD, {r[31:5], 1'b0, 4'(i)});
      bus(1'b0, BMD_IDX_TBL_CMD, 32'h0);
      `CHK(q, {27'h0, 1'b0, 4'(i)})
    end
    // read back in reverse order
    for (int i = 15; i >= 0; i--) begin
      bus(1'b1, BMD_IDX_TBL_CMD, {27'h0, 1'b1, 4'(i)});
      bus(1'b0, BMD_IDX_TBL_RDATA, 32'h0);
      `CHK(q, {22'h0, tbl[i]})
    end
    // lookup at 0, 31, 64, 95, 128, 159, 192 and 223 first, then random levels
    for (int k = 0; k < 200; k++) begin
      r = (k < 8) ? {24'h0, 8'(k[0] ? 32 * k - 1 : 32 * k)} : $random(seed);
      @(posedge clk_i);
      usage <= r[7:0];
      #1 if (k > 0) `CHK(prob, tbl[use_idx(u_prev)])
      u_prev = r[7:0];
    end
    // second reset: port 1 counter clears, table kept
    drops(9);
    boot();
    bus(1'b0, BMD_IDX_PORT1_CNT, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, BMD_IDX_TBL_CMD, 32'h0000_0013);
    bus(1'b0, BMD_IDX_TBL_RDATA, 32'h0);
    `CHK(q, {22'h0, tbl[3]})
    test_done();
  end
endmodule
`default_nettype wire
